// ### verilog/slsh_top.sv
// slsh_top: servo loop option selection and homing start-phase sequencer
// assumes: AHB-Lite single-slave bus on hclk, parameter store on hclk, limit pins async
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`include "slsh_cfg.svh"
module slsh_top
    import slsh_pkg::*;
#(
    parameter logic [15:0] MAX_HOME_SPEED = 16'hFFFF
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [15:0] position_deviation,
    input wire logic [15:0] feedback_speed,
    input wire logic [15:0] command_frequency,
    input wire logic [15:0] command_speed,
    input wire logic signed [19:0] motor_speed,
    input wire logic torque_control_active,
    input wire logic signed [15:0] torque_command,
    input wire logic external_switch_input,
    input wire logic home_ls_input,
    input wire logic positive_travel_limit,
    input wire logic negative_travel_limit,
    input wire logic shift_ref_input,
    input wire logic [1:0] store_home_start_direction,
    input wire logic store_home_approach_direction,
    input wire logic [1:0] store_decel_ref_select,
    input wire logic travel_step,
    output logic p_control_mode,
    output logic load_observer_en,
    output logic friction_comp_en,
    output logic friction_comp_active,
    output logic torque_filter_auto,
    output logic model_filter_auto,
    output logic model_filter_used,
    output logic model_torque_en,
    output logic speed_observer_en,
    output logic torque_ff_en,
    output logic speed_limit_active,
    output logic signed [15:0] torque_limited,
    output logic [2:0] display_point_place,
    output logic [15:0] home_speed_cmd,
    output logic home_move_fwd,
    output logic home_motor_dir,
    output logic home_moving,
    output logic home_shift_start
);
    // magnitude of a signed 20-bit value
    function automatic logic [19:0] mag20(input logic signed [19:0] v);
        mag20 = v[19] ? 20'(-v) : 20'(v);
    endfunction

    // clamp a written field into its legal range
    function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    slsh_sync_if #(.W(`SLSH_IN_COUNT)) sin();
    slsh_sync #(.W(`SLSH_IN_COUNT)) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .pins({shift_ref_input, negative_travel_limit, positive_travel_limit, home_ls_input, external_switch_input}),
        .sync(sin.src)
    );

    // bus state
    slsh_rd_t rd_q, rd_d;
    slsh_home_t home_st_q, home_st_d;
    logic wr_q, wr_d;
    logic [7:0] addr_q, addr_d;
    logic [31:0] rdata_q, rdata_d;
    logic accept;

    // live settings
    logic [15:0] loop_q, loop_d;
    logic [15:0] level_q, level_d;
    logic [15:0] band_q, band_d;
    logic [15:0] coul_q, coul_d;
    logic [15:0] tfilt_q, tfilt_d;
    logic [15:0] mfilt_q, mfilt_d;
    logic [15:0] lgain_q, lgain_d;
    logic [15:0] tmax_q, tmax_d;
    logic [15:0] fast_q, fast_d;
    logic [15:0] slow_q, slow_d;
    logic [31:0] back_q, back_d;
    logic [15:0] disp_q, disp_d;
    logic start_req, abort_req;

    // restart-only captures
    logic boot_q, boot_d;
    logic [1:0] sdir_q, sdir_d;
    logic hdir_q, hdir_d;
    logic [1:0] dref_q, dref_d;

    // address phase accepted only when the bus is ready
    assign accept = hsel & htrans[1] & hready;

    // bus sequencing: writes zero-wait, reads take one wait state
    always_comb begin
        rd_d = RD_NONE;
        wr_d = 1'b0;
        addr_d = addr_q;
        if (rd_q == RD_LOAD) begin
            rd_d = RD_GIVE;
        end else if (accept) begin
            addr_d = haddr[7:0];
            wr_d = hwrite;
            rd_d = hwrite ? RD_NONE : RD_LOAD;
        end
    end

    // read mux, sampled in the wait cycle so a preceding write is visible
    always_comb begin
        rdata_d = rdata_q;
        if (rd_q == RD_LOAD) begin
            unique case (addr_q)
                `SLSH_A_LOOP: rdata_d = {16'h0000, loop_q};
                `SLSH_A_LEVEL: rdata_d = {16'h0000, level_q};
                `SLSH_A_FRIC: rdata_d = {coul_q, band_q};
                `SLSH_A_FILT: rdata_d = {mfilt_q, tfilt_q};
                `SLSH_A_TLIM: rdata_d = {tmax_q, lgain_q};
                `SLSH_A_HSPD: rdata_d = {slow_q, fast_q};
                `SLSH_A_HBACK: rdata_d = back_q;
                `SLSH_A_DISP: rdata_d = {16'h0000, disp_q};
                `SLSH_A_STAT: rdata_d = {24'h000000, friction_comp_active, speed_limit_active,
                                         p_control_mode, home_moving, 1'b0, home_st_q};
                `SLSH_A_BOOT: rdata_d = {27'h0000000, dref_q, hdir_q, sdir_q};
                default: rdata_d = 32'h00000000;
            endcase
        end
    end

    // register writes in the data phase, ranges clamped
    always_comb begin
        loop_d = loop_q;
        level_d = level_q;
        band_d = band_q;
        coul_d = coul_q;
        tfilt_d = tfilt_q;
        mfilt_d = mfilt_q;
        lgain_d = lgain_q;
        tmax_d = tmax_q;
        fast_d = fast_q;
        slow_d = slow_q;
        back_d = back_q;
        disp_d = disp_q;
        start_req = 1'b0;
        abort_req = 1'b0;
        if (wr_q) begin
            unique case (addr_q)
                `SLSH_A_LOOP: loop_d = {1'b0, hwdata[14:0]};
                `SLSH_A_LEVEL: level_d = hwdata[15:0];
                `SLSH_A_FRIC: begin
                    band_d = clamp16(hwdata[15:0], `SLSH_MIN_BAND, `SLSH_MAX_BAND);
                    coul_d = clamp16(hwdata[31:16], 16'h0000, `SLSH_MAX_COUL);
                end
                `SLSH_A_FILT: begin
                    tfilt_d = hwdata[15:0];
                    mfilt_d = hwdata[31:16];
                end
                `SLSH_A_TLIM: begin
                    lgain_d = clamp16(hwdata[15:0], 16'h0000, `SLSH_MAX_LGAIN);
                    tmax_d = hwdata[31:16];
                end
                `SLSH_A_HSPD: begin
                    fast_d = clamp16(hwdata[15:0], `SLSH_MIN_SPEED, MAX_HOME_SPEED);
                    slow_d = clamp16(hwdata[31:16], `SLSH_MIN_SPEED, MAX_HOME_SPEED);
                end
                `SLSH_A_HBACK: back_d = (hwdata > `SLSH_MAX_BACK) ? `SLSH_MAX_BACK : hwdata;
                `SLSH_A_DISP: disp_d = clamp16(hwdata[15:0], 16'h0000, `SLSH_MAX_DISP);
                `SLSH_A_CMD: begin
                    start_req = hwdata[`SLSH_CMD_START];
                    abort_req = hwdata[`SLSH_CMD_ABORT];
                end
                default: begin
                end
            endcase
        end
    end

    // restart-only settings taken from the store once, after reset release
    always_comb begin
        boot_d = 1'b1;
        sdir_d = sdir_q;
        hdir_d = hdir_q;
        dref_d = dref_q;
        if (!boot_q) begin
            sdir_d = store_home_start_direction;
            hdir_d = store_home_approach_direction;
            dref_d = store_decel_ref_select;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q <= RD_NONE;
            wr_q <= 1'b0;
            addr_q <= 8'h00;
            rdata_q <= 32'h00000000;
            loop_q <= {7'h00, `SLSH_RV_MSEL, `SLSH_RV_FMODE, 5'h00};
            level_q <= 16'h0000;
            band_q <= `SLSH_RV_BAND;
            coul_q <= 16'h0000;
            tfilt_q <= 16'h0000;
            mfilt_q <= 16'h0000;
            lgain_q <= `SLSH_RV_LGAIN;
            tmax_q <= 16'h0000;
            fast_q <= `SLSH_RV_FAST;
            slow_q <= `SLSH_RV_SLOW;
            back_q <= 32'h00000000;
            disp_q <= 16'h0000;
            boot_q <= 1'b0;
            sdir_q <= `SLSH_SD_FWD;
            hdir_q <= 1'b0;
            dref_q <= `SLSH_DR_LS;
        end else begin
            rd_q <= rd_d;
            wr_q <= wr_d;
            addr_q <= addr_d;
            rdata_q <= rdata_d;
            loop_q <= loop_d;
            level_q <= level_d;
            band_q <= band_d;
            coul_q <= coul_d;
            tfilt_q <= tfilt_d;
            mfilt_q <= mfilt_d;
            lgain_q <= lgain_d;
            tmax_q <= tmax_d;
            fast_q <= fast_d;
            slow_q <= slow_d;
            back_q <= back_d;
            disp_q <= disp_d;
            boot_q <= boot_d;
            sdir_q <= sdir_d;
            hdir_q <= hdir_d;
            dref_q <= dref_d;
        end
    end

    assign hreadyout = (rd_q != RD_LOAD);
    assign hrdata = rdata_q;
    assign hresp = 1'b0;

    // loop option decode
    logic [2:0] cause;
    logic [1:0] fmode;
    logic [1:0] msel;
    logic [15:0] sample;
    logic [19:0] spd_mag, tq_mag, excess;
    logic [35:0] reduce;
    logic signed [15:0] tq_d;
    logic pmode_d, lim_d, fric_d;

    assign cause = loop_q[`SLSH_F_CAUSE_HI:`SLSH_F_CAUSE_LO];
    assign fmode = loop_q[`SLSH_F_FMODE_HI:`SLSH_F_FMODE_LO];
    assign msel = loop_q[`SLSH_F_MSEL_HI:`SLSH_F_MSEL_LO];
    assign spd_mag = mag20(motor_speed);
    assign tq_mag = mag20(20'(torque_command));
    assign excess = spd_mag - {4'h0, tmax_q};

    // switch mode, friction window and speed-limited torque
    always_comb begin
        unique case (cause)
            `SLSH_C_POSDEV: sample = position_deviation;
            `SLSH_C_FBSPD: sample = feedback_speed;
            `SLSH_C_CMDFRQ: sample = command_frequency;
            `SLSH_C_CMDSPD: sample = command_speed;
            default: sample = 16'h0000;
        endcase
        pmode_d = 1'b0;
        if (loop_q[`SLSH_F_PI]) begin
            if (cause == `SLSH_C_EXT) begin
                pmode_d = sin.level[`SLSH_IN_EXT];
            end else if (cause < `SLSH_C_EXT) begin
                pmode_d = (sample >= level_q);
            end
        end
        fric_d = (coul_q != 16'h0000) && (spd_mag < {4'h0, band_q});
        lim_d = torque_control_active && (spd_mag > {4'h0, tmax_q});
        reduce = ({16'h0000, excess} * {20'h00000, lgain_q}) / `SLSH_GAIN_DIV;
        tq_d = torque_command;
        if (lim_d) begin
            if (reduce >= {16'h0000, tq_mag}) begin
                tq_d = 16'sh0000;
            end else if (torque_command[15]) begin
                tq_d = torque_command + 16'(reduce);
            end else begin
                tq_d = torque_command - 16'(reduce);
            end
        end
    end

    // registered loop outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            p_control_mode <= 1'b0;
            load_observer_en <= 1'b0;
            friction_comp_en <= 1'b0;
            friction_comp_active <= 1'b0;
            torque_filter_auto <= 1'b0;
            model_filter_auto <= 1'b0;
            model_filter_used <= 1'b0;
            model_torque_en <= 1'b0;
            speed_observer_en <= 1'b0;
            torque_ff_en <= 1'b0;
            speed_limit_active <= 1'b0;
            torque_limited <= 16'sh0000;
            display_point_place <= 3'h0;
        end else begin
            p_control_mode <= pmode_d;
            load_observer_en <= loop_q[`SLSH_F_OBS];
            friction_comp_en <= (coul_q != 16'h0000);
            friction_comp_active <= fric_d;
            torque_filter_auto <= (fmode == `SLSH_FM_BOTH) || (fmode == `SLSH_FM_TORQUE);
            model_filter_auto <= (fmode == `SLSH_FM_BOTH) || (fmode == `SLSH_FM_MODEL);
            model_filter_used <= (loop_q[`SLSH_F_TUNE_HI:`SLSH_F_TUNE_LO] != `SLSH_TUNE_TRACE);
            model_torque_en <= msel[0];
            speed_observer_en <= msel[1];
            torque_ff_en <= msel[0];
            speed_limit_active <= lim_d;
            torque_limited <= tq_d;
            display_point_place <= disp_q[2:0];
        end
    end

    // homing start phase
    logic [31:0] cnt_q, cnt_d;
    logic fwd_q, fwd_d;
    logic start_fwd, home_fwd, decel_rise, shift_rise;

    assign shift_rise = sin.rise[`SLSH_IN_SHIFT];
    assign decel_rise = (dref_q == `SLSH_DR_POT) ? sin.rise[`SLSH_IN_POT] :
                        (dref_q == `SLSH_DR_NOT) ? sin.rise[`SLSH_IN_NOT] : sin.rise[`SLSH_IN_LS];
    // judged start heads away from an active limit, else forward
    assign start_fwd = (sdir_q == `SLSH_SD_REV) ? 1'b0 :
                       (sdir_q == `SLSH_SD_JUDGE) ? ~sin.level[`SLSH_IN_POT] : 1'b1;
    // limit reference homes away from that limit
    assign home_fwd = (dref_q == `SLSH_DR_POT) ? 1'b0 :
                      (dref_q == `SLSH_DR_NOT) ? 1'b1 : ~hdir_q;

    always_comb begin
        home_st_d = home_st_q;
        cnt_d = cnt_q;
        fwd_d = fwd_q;
        if (abort_req) begin
            home_st_d = HS_IDLE;
        end else begin
            unique case (home_st_q)
                HS_IDLE: begin
                    if (start_req) begin
                        cnt_d = 32'h00000000;
                        if (back_q == 32'h00000000) begin
                            home_st_d = HS_APPROACH;
                            fwd_d = start_fwd;
                        end else begin
                            home_st_d = HS_BACK;
                            fwd_d = ~start_fwd;
                        end
                    end
                end
                HS_BACK: begin
                    if (decel_rise || shift_rise) begin
                        home_st_d = HS_CREEP;
                        fwd_d = home_fwd;
                    end else if (travel_step) begin
                        cnt_d = cnt_q + 32'h00000001;
                        if (cnt_d >= back_q) begin
                            home_st_d = HS_APPROACH;
                            fwd_d = start_fwd;
                        end
                    end
                end
                HS_APPROACH: begin
                    if (decel_rise) begin
                        home_st_d = HS_CREEP;
                        fwd_d = home_fwd;
                    end
                end
                HS_CREEP: begin
                    if (shift_rise) begin
                        home_st_d = HS_HANDOFF;
                    end
                end
                HS_HANDOFF: begin
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            home_st_q <= HS_IDLE;
            cnt_q <= 32'h00000000;
            fwd_q <= 1'b1;
        end else begin
            home_st_q <= home_st_d;
            cnt_q <= cnt_d;
            fwd_q <= fwd_d;
        end
    end

    // speed and direction handed to the motion generator
    assign home_moving = (home_st_q != HS_IDLE);
    assign home_shift_start = (home_st_q == HS_HANDOFF);
    assign home_move_fwd = fwd_q;
    assign home_motor_dir = fwd_q ^ loop_q[`SLSH_F_SENSE];
    assign home_speed_cmd = (home_st_q == HS_BACK || home_st_q == HS_APPROACH) ? fast_q :
                            (home_st_q == HS_IDLE) ? 16'h0000 : slow_q;
endmodule

// ### verilog/slsh_cfg.svh
// slsh_cfg.svh: register offsets, field positions, reset values and codes
// assumes: included by bare name from the top module and the bench
`ifndef SLSH_CFG_SVH
`define SLSH_CFG_SVH
// byte offsets on the bus
`define SLSH_A_LOOP 8'h00
`define SLSH_A_LEVEL 8'h04
`define SLSH_A_FRIC 8'h08
`define SLSH_A_FILT 8'h0C
`define SLSH_A_TLIM 8'h10
`define SLSH_A_HSPD 8'h14
`define SLSH_A_HBACK 8'h18
`define SLSH_A_DISP 8'h1C
`define SLSH_A_CMD 8'h20
`define SLSH_A_STAT 8'h24
`define SLSH_A_BOOT 8'h28
// loop register fields
`define SLSH_F_PI 0
`define SLSH_F_OBS 1
`define SLSH_F_CAUSE_LO 2
`define SLSH_F_CAUSE_HI 4
`define SLSH_F_FMODE_LO 5
`define SLSH_F_FMODE_HI 6
`define SLSH_F_MSEL_LO 7
`define SLSH_F_MSEL_HI 8
`define SLSH_F_TUNE_LO 9
`define SLSH_F_TUNE_HI 13
`define SLSH_F_SENSE 14
// reset values and limits
`define SLSH_RV_FMODE 2'h1
`define SLSH_RV_MSEL 2'h3
`define SLSH_RV_BAND 16'h0064
`define SLSH_MIN_BAND 16'h0001
`define SLSH_MAX_BAND 16'h00C8
`define SLSH_MAX_COUL 16'h0032
`define SLSH_RV_LGAIN 16'h0028
`define SLSH_MAX_LGAIN 16'h01F4
`define SLSH_RV_FAST 16'hC350
`define SLSH_RV_SLOW 16'h1388
`define SLSH_MIN_SPEED 16'h0001
`define SLSH_MAX_BACK 32'h77359400
`define SLSH_MAX_DISP 16'h0005
`define SLSH_TUNE_TRACE 5'h0E
`define SLSH_GAIN_DIV 36'h00000000A
// gain switch causes
`define SLSH_C_POSDEV 3'h0
`define SLSH_C_FBSPD 3'h1
`define SLSH_C_CMDFRQ 3'h2
`define SLSH_C_CMDSPD 3'h3
`define SLSH_C_EXT 3'h4
// filter automation modes
`define SLSH_FM_MODEL 2'h0
`define SLSH_FM_BOTH 2'h1
`define SLSH_FM_TORQUE 2'h3
// homing codes
`define SLSH_SD_FWD 2'h0
`define SLSH_SD_REV 2'h1
`define SLSH_SD_JUDGE 2'h2
`define SLSH_DR_LS 2'h0
`define SLSH_DR_POT 2'h1
`define SLSH_DR_NOT 2'h2
// command bits and synchroniser lanes
`define SLSH_CMD_START 0
`define SLSH_CMD_ABORT 1
`define SLSH_IN_EXT 0
`define SLSH_IN_LS 1
`define SLSH_IN_POT 2
`define SLSH_IN_NOT 3
`define SLSH_IN_SHIFT 4
`define SLSH_IN_COUNT 5
`endif

// ### verilog/slsh_pkg.sv
// slsh_pkg: state types shared by the block
// assumes: nothing beyond the config header
package slsh_pkg;
    // homing start-phase states
    typedef enum logic [2:0] {HS_IDLE, HS_BACK, HS_APPROACH, HS_CREEP, HS_HANDOFF} slsh_home_t;
    // bus read progress
    typedef enum logic [1:0] {RD_NONE, RD_LOAD, RD_GIVE} slsh_rd_t;
endpackage

// ### verilog/slsh_sync_if.sv
// slsh_sync_if: synchronised levels and rising edges of external inputs
// assumes: one clock shared by producer and consumer
interface slsh_sync_if #(parameter int W = 5);
    logic [W-1:0] level;
    logic [W-1:0] rise;
    modport src(output level, output rise);
    modport dst(input level, input rise);
endinterface

// ### verilog/slsh_sync.sv
// slsh_sync: two-flop synchroniser with rising-edge detect per input lane
// assumes: pins are asynchronous to hclk
module slsh_sync #(
    parameter int W = 5
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [W-1:0] pins,
    slsh_sync_if.src sync
);
    logic [W-1:0] meta_q, meta_d;
    logic [W-1:0] stab_q, stab_d;
    logic [W-1:0] prev_q, prev_d;

    // next stages; only the second and third stages are looked at
    always_comb begin
        meta_d = pins;
        stab_d = meta_q;
        prev_d = stab_q;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= '0;
            stab_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= meta_d;
            stab_q <= stab_d;
            prev_q <= prev_d;
        end
    end

    // level and one-cycle edge from settled stages
    assign sync.level = stab_q;
    assign sync.rise = stab_q & ~prev_q;
endmodule

// ### verification/slsh_motor.sv
// slsh_motor: motor and encoder stand-in for the homing sequencer
// assumes: travel_step is sampled on hclk
module slsh_motor (
    input wire logic hclk,
    input wire logic home_moving,
    output logic travel_step
);
    timeunit 1ns;
    timeprecision 1ns;
    initial travel_step = 1'b0;
    // one unit of travel every other cycle while moving
    always @(posedge hclk) begin
        travel_step <= home_moving & ~travel_step;
    end
endmodule

// ### verification/slsh_assertions.sv
// slsh_assertions: port-level checks of the loop selector and homing outputs
// assumes: bound into slsh_top, one clock
module slsh_assertions (
    input wire logic hclk, hresetn, hreadyout, hresp, torque_control_active,
    input wire logic model_torque_en, torque_ff_en, friction_comp_en, friction_comp_active,
    input wire logic speed_limit_active, p_control_mode, home_moving, home_shift_start,
    input wire logic signed [15:0] torque_command, torque_limited,
    input wire logic [2:0] display_point_place,
    input wire logic [15:0] home_speed_cmd
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("hresp not okay");
    chk_read_wait: assert property (!hreadyout |=> hreadyout)
        else $error("read wait too long");
    chk_ff_model: assert property (!model_torque_en |-> !torque_ff_en)
        else $error("feed-forward without model torque");
    chk_fric_gate: assert property (friction_comp_active |-> friction_comp_en)
        else $error("friction active while disabled");
    chk_limit_mode: assert property (speed_limit_active |-> $past(torque_control_active))
        else $error("speed limit outside torque control");
    chk_torque_pass: assert property ($past(hresetn) && !speed_limit_active |-> torque_limited == $past(torque_command))
        else $error("torque changed without limit");
    chk_speed_min: assert property (home_moving |-> home_speed_cmd >= 16'h0001)
        else $error("homing speed zero while moving");
    chk_point_max: assert property (display_point_place <= 3'h5)
        else $error("decimal place code out of range");
    cover property (home_shift_start);
    cover property (speed_limit_active);
    cover property (p_control_mode ##1 !p_control_mode);
endmodule
bind slsh_top slsh_assertions i_chk (.*);

// ### verification/slsh_top_bench.sv
// slsh_top_bench: directed scenarios for loop selection, bus and homing
// assumes: slsh_top, slsh_motor and the bound checker
`include "slsh_cfg.svh"
module slsh_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, torque_control_active = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0, store_home_start_direction = 2'h0, store_decel_ref_select = 2'h0;
    logic [2:0] hsize = 3'h2, display_point_place;
    logic [15:0] position_deviation = 16'h0, feedback_speed = 16'h0, command_frequency = 16'h0;
    logic [15:0] command_speed = 16'h0, home_speed_cmd;
    logic signed [19:0] motor_speed = 20'sh0;
    logic signed [15:0] torque_command = 16'sh0, torque_limited;
    logic external_switch_input = 1'b0, home_ls_input = 1'b0, positive_travel_limit = 1'b0;
    logic negative_travel_limit = 1'b0, shift_ref_input = 1'b0, store_home_approach_direction = 1'b0;
    logic travel_step, hreadyout, hresp, p_control_mode, load_observer_en, friction_comp_en;
    logic friction_comp_active, torque_filter_auto, model_filter_auto, model_filter_used;
    logic model_torque_en, speed_observer_en, torque_ff_en, speed_limit_active;
    logic home_move_fwd, home_motor_dir, home_moving, home_shift_start;
    int bad_count = 0, num_checks = 0;
    slsh_top i_dut (.hready(hreadyout), .*);
    slsh_motor i_motor (.hclk(hclk), .home_moving(home_moving), .travel_step(travel_step));
    // 100 MHz clock
    always #5 hclk = ~hclk;
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            $display("Error %s expected %h seen %h", nm, e, s);
            bad_count++;
        end
    endtask
    // bounded wait, sampled mid-cycle
    task automatic hold(ref logic s, input logic v);
        for (int n = 0; n < 300; n++) begin
            @(negedge hclk);
            if (s === v) return;
        end
        bad_count++;
        print_verdict();
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask
    // one AHB single transfer; data taken with hready high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        hold(hreadyout, 1'b1);
        @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        hold(hreadyout, 1'b1);
        @(posedge hclk);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
        step(3);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        chk("hrdata", e, r);
    endtask
    task automatic t_reset();
        step(2);
        chk("defaults", 32'h1F, {model_torque_en, speed_observer_en, torque_filter_auto, model_filter_auto,
            model_filter_used});
        chk("off", 0, {load_observer_en, friction_comp_en, display_point_place});
        rd(`SLSH_A_HSPD, 32'h1388C350);
        rd(`SLSH_A_FRIC, 32'h00000064);
        rd(`SLSH_A_TLIM, 32'h00000028);
        rd(8'h40, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_loop();
        for (int i = 0; i < 4; i++) begin
            wr(`SLSH_A_LOOP, (i << 7) | (i << 5));
            chk("msel", {i[0], i[1], i[0]}, {model_torque_en, speed_observer_en, torque_ff_en});
            chk("fmode", {i[0], ~i[1]}, {torque_filter_auto, model_filter_auto});
        end
        wr(`SLSH_A_LOOP, 32'h1DA0);
        chk("mfused", 0, model_filter_used);
        $display("loop test done");
    endtask
    task automatic t_pi();
        wr(`SLSH_A_LEVEL, 32'h64);
        wr(`SLSH_A_LOOP, 32'h1A5);
        feedback_speed <= 16'h64;
        step(2);
        chk("p level", 1, p_control_mode);
        feedback_speed <= 16'h63;
        step(2);
        chk("pi below", 0, p_control_mode);
        wr(`SLSH_A_LOOP, 32'h1B1);
        external_switch_input <= 1'b1;
        step(6);
        chk("p ext", 1, p_control_mode);
        wr(`SLSH_A_LOOP, 32'h1B2);
        chk("pi off", 1, {p_control_mode, load_observer_en});
        external_switch_input <= 1'b0;
        wr(`SLSH_A_FRIC, 32'h003300C9);
        chk("fric", 3, {friction_comp_en, friction_comp_active});
        rd(`SLSH_A_FRIC, 32'h003200C8);
        wr(`SLSH_A_DISP, 32'h7);
        chk("point", 5, display_point_place);
        $display("option test done");
    endtask
    task automatic t_torq();
        wr(`SLSH_A_TLIM, 32'h00640028);
        torque_control_active <= 1'b1;
        motor_speed <= 20'sd200;
        torque_command <= 16'sd1000;
        step(2);
        chk("tlim", 32'h10258, {speed_limit_active, torque_limited});
        torque_control_active <= 1'b0;
        step(2);
        chk("tpass", 32'h03E8, {speed_limit_active, torque_limited});
        $display("torque test done");
    endtask
    task automatic t_home();
        wr(`SLSH_A_HBACK, 32'h8);
        wr(`SLSH_A_CMD, 32'h1);
        chk("back", 32'hC350, {home_move_fwd, home_speed_cmd});
        hold(home_move_fwd, 1'b1);
        wr(`SLSH_A_LOOP, 32'h4000);
        chk("dir", 0, home_motor_dir);
        home_ls_input <= 1'b1;
        step(1);
        chk("sync", 32'hC350, home_speed_cmd);
        step(5);
        chk("creep", 32'h11388, {home_move_fwd, home_speed_cmd});
        shift_ref_input <= 1'b1;
        step(6);
        chk("handoff", 1, home_shift_start);
        wr(`SLSH_A_CMD, 32'h2);
        chk("abort", 0, home_moving);
        home_ls_input <= 1'b0;
        shift_ref_input <= 1'b0;
        wr(`SLSH_A_HBACK, 32'h3E8);
        wr(`SLSH_A_CMD, 32'h1);
        shift_ref_input <= 1'b1;
        step(6);
        chk("turn", 32'h11388, {home_move_fwd, home_speed_cmd});
        wr(`SLSH_A_CMD, 32'h2);
        shift_ref_input <= 1'b0;
        $display("homing test done");
    endtask
    task automatic t_ot();
        hresetn <= 1'b0;
        store_decel_ref_select <= 2'h1;
        store_home_start_direction <= 2'h2;
        step(2);
        hresetn <= 1'b1;
        wr(`SLSH_A_CMD, 32'h1);
        store_decel_ref_select <= 2'h2;
        chk("noback", 1, home_move_fwd);
        positive_travel_limit <= 1'b1;
        step(6);
        chk("ot dir", 32'h01388, {home_move_fwd, home_speed_cmd});
        $display("limit test done");
    endtask
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_loop();
        t_pi();
        t_torq();
        t_home();
        t_ot();
        print_verdict();
    end
endmodule
